// File: pkg/wwdt_pkg.sv
// Constants for the window watchdog timer
`default_nettype none
package wwdt_pkg;
    localparam int unsigned CLK_HZ         = 125000000;
    localparam int unsigned UPPER_MS       = 1600;
    localparam int unsigned LOWER_MS       = 800;
    localparam int unsigned TIMEOUT_MS     = 200;
    // Time base: one tick per millisecond
    localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000;
    localparam logic [16:0] TICK_LAST      = 17'(TICK_CYCLES - 1);
    localparam logic [11:0] UPPER_TICKS    = 12'(UPPER_MS);
    localparam logic [11:0] LOWER_TICKS    = 12'(LOWER_MS);
    localparam logic [11:0] TIMEOUT_TICKS  = 12'(TIMEOUT_MS);
    localparam logic [1:0]  RATIO_HALF     = 2'h0;
    localparam logic [1:0]  RATIO_QUARTER  = 2'h1;
    localparam logic [1:0]  RATIO_EIGHTH   = 2'h2;
    localparam logic [1:0]  RATIO_NONE     = 2'h3;
    typedef enum logic [3:0] {
        ST_ARM    = 4'h1,
        ST_WINDOW = 4'h2,
        ST_FAULT  = 4'h4,
        ST_OFF    = 4'h8
    } wd_state_type;
endpackage
`default_nettype wire

// File: logic/window_watchdog_timer.sv
// Window watchdog timer supervising periodic falling-edge kicks
// Functional notes
// [RL1] Lower boundary is half the upper: 1600 ms upper, 800 ms lower.
// [RL2] With no kick edge, fault output stays high until upper boundary elapses.
// [RL3] On any fault, drive fault output low for 200 ms, then release.
// [RL4] After release, first falling edge starts the window, unchecked.
// [RL5] Kicks spaced 800 to 1600 ms apart keep the fault output high.
// [RL6] Edge before lower boundary flags early fault, output goes low.
// [RL7] No edge within upper boundary flags late fault, output goes low.
// [RL8] After timeout, release output high and rearm on next edge.
// [RL9] Window timeouts and ratio configurable; watchdog can be disabled.
// [RL10] Internal time base restarts on accepted edges and timeout end.
`default_nettype none
module window_watchdog_timer (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        watchdog_kick_input,
    input  wire logic        wd_enable,
    input  wire logic [1:0]  window_ratio,
    input  wire logic [11:0] upper_ms,
    input  wire logic [11:0] timeout_ms,
    output logic             watchdog_fault_output,
    output logic             early_fault,
    output logic             late_fault
);
    typedef struct packed {
        logic                 sync1;
        logic                 sync2;
        logic                 kick_prev;
        logic [16:0]          prescale;
        logic [11:0]          elapsed;
        wwdt_pkg::wd_state_type state;
        logic                 fault_out;
        logic                 early;
        logic                 late;
        logic                 armed_init;
    } wd_regs_type;

    wd_regs_type cur;
    wd_regs_type next_cur;
    logic        fall;
    logic        tick;
    logic [11:0] lower;
    logic [11:0] upper;
    logic [11:0] tmo;

    // Configured bounds; zero selects the fixed option
    always_comb begin
        upper = (upper_ms == 12'h000) ? wwdt_pkg::UPPER_TICKS : upper_ms;
        tmo   = (timeout_ms == 12'h000) ? wwdt_pkg::TIMEOUT_TICKS : timeout_ms;
        // [RL1] ratio derived lower bound
        case (window_ratio)
            wwdt_pkg::RATIO_HALF:    lower = {1'b0, upper[11:1]};
            wwdt_pkg::RATIO_QUARTER: lower = {2'b00, upper[11:2]};
            wwdt_pkg::RATIO_EIGHTH:  lower = {3'b000, upper[11:3]};
            default:                 lower = 12'h000;
        endcase
    end

    assign fall = cur.kick_prev & ~cur.sync2;
    assign tick = (cur.prescale == wwdt_pkg::TICK_LAST);

    // Next-state logic
    always_comb begin
        next_cur = cur;
        next_cur.sync1 = watchdog_kick_input;
        next_cur.sync2 = cur.sync1;
        next_cur.kick_prev = cur.sync2;
        // [RL10] free-running time base
        next_cur.prescale = tick ? 17'h00000 : cur.prescale + 17'h00001;
        if (tick && cur.elapsed != 12'hfff) begin
            next_cur.elapsed = cur.elapsed + 12'h001;
        end
        next_cur.early = 1'b0;
        next_cur.late = 1'b0;
        case (cur.state)
            wwdt_pkg::ST_ARM: begin
                next_cur.fault_out = 1'b1;
                // [RL4] first edge unchecked
                if (fall) begin
                    next_cur.state = wwdt_pkg::ST_WINDOW;
                    next_cur.prescale = 17'h00000;
                    next_cur.elapsed = 12'h000;
                end
            end
            wwdt_pkg::ST_WINDOW: begin
                // [RL7] late fault
                if (cur.elapsed >= upper) begin
                    next_cur.state = wwdt_pkg::ST_FAULT;
                    next_cur.fault_out = 1'b0;
                    next_cur.late = 1'b1;
                    next_cur.prescale = 17'h00000;
                    next_cur.elapsed = 12'h000;
                end else if (fall) begin
                    // [RL6] early fault
                    if (cur.elapsed < lower) begin
                        next_cur.state = wwdt_pkg::ST_FAULT;
                        next_cur.fault_out = 1'b0;
                        next_cur.early = 1'b1;
                    end
                    // [RL5] good kick restarts window
                    next_cur.prescale = 17'h00000;
                    next_cur.elapsed = 12'h000;
                end
            end
            wwdt_pkg::ST_FAULT: begin
                // [RL3] hold low for timeout
                next_cur.fault_out = 1'b0;
                if (cur.elapsed >= tmo) begin
                    // [RL8] release and rearm
                    next_cur.fault_out = 1'b1;
                    next_cur.state = wwdt_pkg::ST_ARM;
                    next_cur.prescale = 17'h00000;
                    next_cur.elapsed = 12'h000;
                end
            end
            wwdt_pkg::ST_OFF: begin
                next_cur.fault_out = 1'b1;
                next_cur.elapsed = 12'h000;
            end
            default: begin
                next_cur.state = wwdt_pkg::ST_OFF;
            end
        endcase
        // [RL2] after reset, run as if first edge seen: upper bound from start
        if (cur.armed_init && cur.state == wwdt_pkg::ST_OFF && wd_enable) begin
            next_cur.state = wwdt_pkg::ST_WINDOW;
            next_cur.prescale = 17'h00000;
            next_cur.elapsed = 12'h000;
            next_cur.armed_init = 1'b0;
        end else if (!wd_enable) begin
            // [RL9] disable, restart window on re-enable
            next_cur.state = wwdt_pkg::ST_OFF;
            next_cur.fault_out = 1'b1;
            next_cur.early = 1'b0;  // No fault pulse while disabled
            next_cur.late = 1'b0;
            next_cur.armed_init = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cur <= '{sync1: 1'b1, sync2: 1'b1, kick_prev: 1'b1, prescale: 17'h00000,
                     elapsed: 12'h000, state: wwdt_pkg::ST_OFF, fault_out: 1'b1,
                     early: 1'b0, late: 1'b0, armed_init: 1'b1};
        end else begin
            cur <= next_cur;
        end
    end

    assign watchdog_fault_output = cur.fault_out;
    assign early_fault = cur.early;
    assign late_fault = cur.late;
endmodule // window_watchdog_timer
`default_nettype wire

// File: verification/kick_driver.sv
// Partner model: controller issuing kick falling edges
`default_nettype none
module kick_driver (
    input  wire logic ref_clk,
    input  wire logic signed [31:0] gap,
    output var logic  kick = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    always @(posedge ref_clk) begin
        cnt <= (gap == 0 || cnt >= gap - 1) ? 0 : cnt + 1;
        kick <= !(gap != 0 && cnt < 64);
    end
endmodule // kick_driver
`default_nettype wire

// File: verification/window_watchdog_timer_assertions.sv
// Checker for the window watchdog timer ports
`default_nettype none
module window_watchdog_timer_assertions (
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic        watchdog_kick_input,
    input wire logic        wd_enable,
    input wire logic [1:0]  window_ratio,
    input wire logic [11:0] upper_ms,
    input wire logic [11:0] timeout_ms,
    input wire logic        watchdog_fault_output,
    input wire logic        early_fault,
    input wire logic        late_fault
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_trip; early_fault || late_fault; endsequence
    a_trip_drives_low: assert property (s_trip |-> !watchdog_fault_output)
        else $error("trip without low output");
    a_early_single: assert property (early_fault |=> !early_fault)
        else $error("early pulse too long");
    a_late_single: assert property (late_fault |=> !late_fault)
        else $error("late pulse too long");
    a_one_kind: assert property (!(early_fault && late_fault))
        else $error("both fault kinds at once");
    a_fall_cause: assert property ($fell(watchdog_fault_output) |-> s_trip)
        else $error("output fell without trip");
    a_low_holds: assert property ($fell(watchdog_fault_output) |=> !watchdog_fault_output [*8])
        else $error("low phase too short");
    a_trip_from_high: assert property (s_trip |-> $past(watchdog_fault_output))
        else $error("trip while already low");
    a_off_quiet: assert property (!wd_enable [*2] |-> watchdog_fault_output && !early_fault && !late_fault)
        else $error("disabled watchdog tripped");
endmodule // window_watchdog_timer_assertions
bind window_watchdog_timer window_watchdog_timer_assertions chk_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .watchdog_kick_input(watchdog_kick_input), .wd_enable(wd_enable),
    .window_ratio(window_ratio), .upper_ms(upper_ms), .timeout_ms(timeout_ms),
    .watchdog_fault_output(watchdog_fault_output), .early_fault(early_fault),
    .late_fault(late_fault));
`default_nettype wire

// File: verification/window_watchdog_timer_tb.sv
// Self-checking bench for the window watchdog timer
`default_nettype none
module window_watchdog_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 125000;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, wd_enable = 1'b1;
    logic [1:0]  window_ratio = 2'h0;
    logic [11:0] upper_ms = 12'h002, timeout_ms = 12'h001;
    logic        kick, fault, early, late;
    logic [31:0] seed = 32'h4b2c;
    int          gap = 0, error_cnt = 0, n_compared = 0, t;
    always #4 ref_clk = ~ref_clk;
    kick_driver mcu (.ref_clk(ref_clk), .gap(gap), .kick(kick));
    window_watchdog_timer dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .watchdog_kick_input(kick), .wd_enable(wd_enable), .window_ratio(window_ratio),
        .upper_ms(upper_ms), .timeout_ms(timeout_ms), .watchdog_fault_output(fault),
        .early_fault(early), .late_fault(late));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: fault output timing", $time);
        end
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Wait on late (0), early (1) or released output (2)
    task automatic wait_lvl(input int sel, input int lim);
        t = 0;
        while ((sel == 0 ? late : sel == 1 ? early : fault) !== 1'b1 && t < lim) begin
            @(posedge ref_clk);
            #1;
            t++;
        end
        if (t >= lim) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task automatic low_cycles(input int n);
        t = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            t += int'(fault === 1'b0);
        end
    endtask
    // Main sequence: late, good window, early, ratio, disable
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        wait_lvl(0, 3 * T);
        chk(t >= 2 * T - 8 && t <= 2 * T + 16, 1'b1);
        wait_lvl(2, 2 * T);
        chk(t >= T - 8 && t <= T + 16, 1'b1);
        repeat (3) begin
            seed = lfsr(seed);
            gap <= T + T / 4 + int'(seed % (T / 2));
            low_cycles(2 * T);
            chk(t == 0, 1'b1);
        end
        gap <= T / 2;
        wait_lvl(1, 2 * T);
        chk(fault, 1'b0);
        gap <= 0;
        wait_lvl(2, 2 * T);
        chk(t >= T - 8 && t <= T + 16, 1'b1);
        window_ratio <= 2'h3;
        gap <= T / 2;
        low_cycles(3 * T);
        chk(t == 0, 1'b1);
        wd_enable <= 1'b0;
        gap <= 0;
        low_cycles(3 * T);
        chk(t == 0, 1'b1);
        wd_enable <= 1'b1;
        wait_lvl(0, 3 * T);
        chk(t >= 2 * T - 8 && t <= 2 * T + 16, 1'b1);
        stop_test();
    end
endmodule // window_watchdog_timer_tb
`default_nettype wire
